// ---- design/icfg_pkg.sv ----
// Purpose: constants for the interpolator configuration register bank
// Assumes: 8-bit registers on a 16-bit register address
// Notes: masks clear reserved bits so that they read as zero
package icfg_pkg;
    localparam logic [15:0] ADDR_CORE = 16'h0000;
    localparam logic [15:0] ADDR_LAMP = 16'h0001;
    localparam logic [15:0] ADDR_START = 16'h0002;
    localparam logic [15:0] ADDR_TEST = 16'h000B;
    localparam logic [15:0] ADDR_DUTY = 16'h0010;
    localparam logic [15:0] ADDR_COMM = 16'h0100;
    localparam logic [15:0] ADDR_ELOW = 16'h0101;
    localparam logic [15:0] ADDR_EHIGH = 16'h0102;
    localparam logic [7:0] MASK_CORE = 8'h3F;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam logic [7:0] MASK_TEST = 8'h05;
    localparam logic [7:0] MASK_COMM = 8'h1F;
    localparam logic [7:0] MASK_EHIGH = 8'h1F;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int CORE_RANGE = 0;
    localparam int CORE_FILTER = 2;
    localparam int CORE_DRIVER = 3;
    localparam int CORE_IRQ_PP = 4;
    localparam int CORE_LINK_OFF = 5;
    localparam int LAMP_ON = 0;
    localparam int LAMP_INV = 1;
    localparam int LAMP_OD = 2;
    localparam int LAMP_AUTO = 3;
    localparam int LAMP_FREQ = 4;
    localparam int LAMP_BUF = 6;
    localparam int TEST_UNLOCK = 0;
    localparam int TEST_INDEX = 2;
    localparam int EHIGH_MSBS = 0;
    localparam int EHIGH_DIV = 2;
    localparam logic [1:0] RANGE_LOW = 2'h0;
    localparam logic [1:0] RANGE_LOW_LOSS = 2'h1;
    localparam logic [1:0] RANGE_HIGH_LOSS = 2'h2;
    localparam logic [8:0] LAMP_BUF_STEP = 9'h008;
    localparam logic [7:0] DUTY_MAX = 8'hFF;
    localparam logic [7:0] DUTY_MIN = 8'h00;
    localparam logic [5:0] POLE_ZERO_CYCLES = 6'h20;
    localparam logic [8:0] INTERP_ZERO_CYCLES = 9'h100;
    localparam logic [9:0] INTERP_MIN_CODE = 10'h008;
    localparam int CLK_HZ = 50_000_000;
    localparam int DSM_TOP_HZ = 25_000_000;
    localparam int DSM_BASE_DIV = CLK_HZ / DSM_TOP_HZ;
    localparam int ADJ_PERIOD_DEFAULT = 1024;
endpackage

// ---- design/icfg_lamp_if.sv ----
// Purpose: duty and rate to the lamp modulator, modulated bit back
// Assumes: one clock domain
// Notes: none
`timescale 1ns/10ps
interface icfg_lamp_if;
    logic [7:0] duty;
    logic [1:0] rate;
    logic mod_bit;
    modport ctrl (output duty, output rate, input mod_bit);
    modport modu (input duty, input rate, output mod_bit);
endinterface

// ---- design/icfg_lamp_dsm.sv ----
// Purpose: first-order delta-sigma modulator for the lamp pin
// Assumes: step rate is the clock divided by 2, 4, 8 or 16
// Notes: duty 255 still leaves one low step in 256
`timescale 1ns/10ps
module icfg_lamp_dsm (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    icfg_lamp_if.modu lamp
);
    typedef struct packed {
        logic [4:0] cnt;
        logic [7:0] acc;
        logic mod_bit;
    } icfg_dsm_type;

    icfg_dsm_type st_reg;
    icfg_dsm_type st_next;
    logic [4:0] last;
    logic [8:0] sum;

    always_comb begin
        last = 5'((icfg_pkg::DSM_BASE_DIV << (2'h3 - lamp.rate)) - 1);
        sum = {1'b0, st_reg.acc} + {1'b0, lamp.duty};
        st_next = st_reg;
        if (st_reg.cnt >= last) begin
            st_next.cnt = 5'h00;
            st_next.acc = sum[7:0];
            st_next.mod_bit = sum[8];
        end else begin
            st_next.cnt = st_reg.cnt + 5'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign lamp.mod_bit = st_reg.mod_bit;
endmodule // icfg_lamp_dsm

// ---- design/icfg_ratio_decode.sv ----
// Purpose: decodes pole pairs, interpolation factor and post divider
// Assumes: register values may change at any cycle
// Notes: reserved interpolation codes give zero cycles and a flag
`timescale 1ns/10ps
module icfg_ratio_decode (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] comm_i,
    input wire logic [7:0] elow_i,
    input wire logic [7:0] ehigh_i,
    output logic [5:0] pole_cycles_o,
    output logic [9:0] interp_code_o,
    output logic [8:0] output_cycles_o,
    output logic interp_reserved_o,
    output logic post_div_on_o,
    output logic [3:0] post_div_ratio_o
);
    typedef struct packed {
        logic [5:0] pole;
        logic [9:0] code;
        logic [8:0] cycles;
        logic rsv;
        logic div_on;
        logic [3:0] ratio;
    } icfg_dec_type;

    icfg_dec_type st_reg;
    icfg_dec_type st_next;
    logic [2:0] div_field;

    always_comb begin
        st_next = st_reg;
        div_field = ehigh_i[icfg_pkg::EHIGH_DIV +: 3];
        st_next.pole = (comm_i[4:0] == 5'h00) ? icfg_pkg::POLE_ZERO_CYCLES
                       : {1'b0, comm_i[4:0]};
        st_next.code = {ehigh_i[icfg_pkg::EHIGH_MSBS +: 2], elow_i};
        st_next.rsv = (st_next.code != 10'h000)
                      && (st_next.code < icfg_pkg::INTERP_MIN_CODE);
        if (st_next.code == 10'h000) begin
            st_next.cycles = icfg_pkg::INTERP_ZERO_CYCLES;
        end else if (st_next.rsv) begin
            st_next.cycles = 9'h000;
        end else begin
            st_next.cycles = {1'b0, st_next.code[9:2]};
        end
        st_next.div_on = (div_field != 3'h0);
        st_next.ratio = {1'b0, div_field} + 4'h1;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pole_cycles_o = st_reg.pole;
    assign interp_code_o = st_reg.code;
    assign output_cycles_o = st_reg.cycles;
    assign interp_reserved_o = st_reg.rsv;
    assign post_div_on_o = st_reg.div_on;
    assign post_div_ratio_o = st_reg.ratio;
endmodule // icfg_ratio_decode

// ---- design/icfg_regs.sv ----
// Purpose: configuration register bank of the sin/cos interpolator
// Assumes: register port and restore port come from core-clock logic
// Notes: restore writes the stored registers, restore_done ends startup
`timescale 1ns/10ps
module icfg_regs #(
    parameter int ADJ_PERIOD = icfg_pkg::ADJ_PERIOD_DEFAULT
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic nvm_load_i,
    input wire logic [15:0] nvm_addr_i,
    input wire logic [7:0] nvm_data_i,
    input wire logic nvm_done_i,
    input wire logic nvm_cmd_write_i,
    output logic nvm_write_o,
    input wire logic calibrate_pin_n_i,
    input wire logic calib_cmd_active_i,
    input wire logic [7:0] signal_amplitude_i,
    input wire logic [7:0] amplitude_low_limit_i,
    input wire logic [7:0] amplitude_high_limit_i,
    input wire logic link_activate_i,
    output logic link_active_o,
    input wire logic irq_request_i,
    output logic interrupt_out_n_o,
    output logic interrupt_out_n_oe_o,
    output logic lamp_o,
    output logic lamp_oe_o,
    input wire logic quad_outputs_enabled_i,
    input wire logic quad_a_i,
    input wire logic quad_b_i,
    input wire logic quad_z_i,
    input wire logic raw_index_i,
    input wire logic index_window_i,
    input wire logic gated_index_i,
    output logic quad_a_o,
    output logic quad_b_o,
    output logic quad_z_o,
    output logic [1:0] input_range_o,
    output logic sensor_loss_detect_o,
    output logic high_range_atten_o,
    output logic heavy_filter_o,
    output logic line_driver_on_o,
    output logic [5:0] pole_cycles_o,
    output logic [9:0] interp_code_o,
    output logic [8:0] output_cycles_o,
    output logic interp_reserved_o,
    output logic post_div_on_o,
    output logic [3:0] post_div_ratio_o
);
    generate
        if (ADJ_PERIOD < 2 || ADJ_PERIOD > 65535) begin : g_bad_period
            $error("ADJ_PERIOD must lie in 2 to 65535");
        end
    endgenerate

    localparam logic [15:0] ADJ_LAST = 16'(ADJ_PERIOD - 1);

    typedef struct packed {
        logic [7:0] core;
        logic [7:0] lamp;
        logic [7:0] start;
        logic [7:0] test;
        logic [7:0] duty;
        logic [7:0] comm;
        logic [7:0] elow;
        logic [7:0] ehigh;
        logic [7:0] rdata;
        logic rvalid;
        logic link_active;
        logic nvm_wr;
        logic [1:0] cal_sync;
        logic cal_prev;
        logic irq_out;
        logic irq_oe;
        logic lamp_pin;
        logic lamp_oe;
        logic qa;
        logic qb;
        logic qz;
        logic [15:0] adj_cnt;
    } icfg_state_type;

    icfg_state_type st_reg;
    icfg_state_type st_next;
    icfg_lamp_if lif ();

    logic calibrating;
    logic cal_rise;
    logic lamp_on;
    logic auto_on;
    logic adj_tick;
    logic amp_low;
    logic amp_high;
    logic lamp_val;
    logic wr_any;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
    logic [8:0] buf_amt;

    // the pin is asynchronous; only cal_sync[1] feeds logic
    assign calibrating = !st_reg.cal_sync[1] || calib_cmd_active_i;
    assign cal_rise = st_reg.cal_sync[1] && !st_reg.cal_prev;
    assign lamp_on = st_reg.lamp[icfg_pkg::LAMP_ON];
    assign auto_on = lamp_on && st_reg.lamp[icfg_pkg::LAMP_AUTO];
    assign adj_tick = (st_reg.adj_cnt == ADJ_LAST);
    assign buf_amt = {7'h00, st_reg.lamp[icfg_pkg::LAMP_BUF +: 2]}
                     * icfg_pkg::LAMP_BUF_STEP + icfg_pkg::LAMP_BUF_STEP;
    // compare as amp + buf > high so a small high limit cannot wrap
    assign amp_low = {1'b0, signal_amplitude_i}
                     < ({1'b0, amplitude_low_limit_i} + buf_amt);
    assign amp_high = ({1'b0, signal_amplitude_i} + buf_amt)
                      > {1'b0, amplitude_high_limit_i};
    assign lamp_val = st_reg.lamp[icfg_pkg::LAMP_INV] ^ lif.mod_bit;

    // restore traffic takes the same write path as the register port
    assign wr_any = nvm_load_i || reg_wr_i;
    assign wr_addr = nvm_load_i ? nvm_addr_i : reg_addr_i;
    assign wr_data = nvm_load_i ? nvm_data_i : reg_wdata_i;

    assign lif.duty = calibrating ? st_reg.start : st_reg.duty;
    assign lif.rate = st_reg.lamp[icfg_pkg::LAMP_FREQ +: 2];

    always_comb begin
        st_next = st_reg;
        st_next.cal_sync = {st_reg.cal_sync[0], calibrate_pin_n_i};
        st_next.cal_prev = st_reg.cal_sync[1];
        st_next.adj_cnt = adj_tick ? 16'h0000 : st_reg.adj_cnt + 16'h0001;

        if (auto_on && !calibrating && adj_tick) begin
            if (amp_low && st_reg.duty != icfg_pkg::DUTY_MAX) begin
                st_next.duty = st_reg.duty + 8'h01;
            end else if (amp_high && st_reg.duty != icfg_pkg::DUTY_MIN) begin
                st_next.duty = st_reg.duty - 8'h01;
            end
        end

        if (wr_any) begin
            unique case (wr_addr)
                icfg_pkg::ADDR_CORE: begin
                    st_next.core = wr_data & icfg_pkg::MASK_CORE;
                end
                icfg_pkg::ADDR_LAMP: begin
                    st_next.lamp = wr_data & icfg_pkg::MASK_FULL;
                end
                icfg_pkg::ADDR_START: begin
                    st_next.start = wr_data;
                end
                icfg_pkg::ADDR_TEST: begin
                    // never taken from memory
                    if (!nvm_load_i) begin
                        st_next.test = wr_data & icfg_pkg::MASK_TEST;
                    end
                end
                icfg_pkg::ADDR_DUTY: begin
                    // a write beats the control loop step
                    st_next.duty = wr_data;
                end
                icfg_pkg::ADDR_COMM: begin
                    st_next.comm = wr_data & icfg_pkg::MASK_COMM;
                end
                icfg_pkg::ADDR_ELOW: begin
                    st_next.elow = wr_data;
                end
                icfg_pkg::ADDR_EHIGH: begin
                    st_next.ehigh = wr_data & icfg_pkg::MASK_EHIGH;
                end
                default: begin
                end
            endcase
        end

        if (nvm_done_i) begin
            st_next.test = icfg_pkg::REG_RESET;
            if (lamp_on) begin
                st_next.duty = st_reg.start;
            end
        end

        st_next.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                icfg_pkg::ADDR_CORE: st_next.rdata = st_reg.core;
                icfg_pkg::ADDR_LAMP: st_next.rdata = st_reg.lamp;
                icfg_pkg::ADDR_START: st_next.rdata = st_reg.start;
                icfg_pkg::ADDR_TEST: st_next.rdata = st_reg.test;
                icfg_pkg::ADDR_DUTY: st_next.rdata = st_reg.duty;
                icfg_pkg::ADDR_COMM: st_next.rdata = st_reg.comm;
                icfg_pkg::ADDR_ELOW: st_next.rdata = st_reg.elow;
                icfg_pkg::ADDR_EHIGH: st_next.rdata = st_reg.ehigh;
                default: st_next.rdata = 8'h00;
            endcase
        end

        if (link_activate_i && !st_reg.core[icfg_pkg::CORE_LINK_OFF]) begin
            st_next.link_active = 1'b1;
        end

        st_next.nvm_wr = cal_rise
                         || (nvm_cmd_write_i
                             && st_reg.test[icfg_pkg::TEST_UNLOCK]);

        st_next.irq_out = !irq_request_i;
        if (st_reg.core[icfg_pkg::CORE_IRQ_PP]) begin
            st_next.irq_oe = 1'b1;
        end else begin
            st_next.irq_oe = irq_request_i;
        end

        if (calibrating) begin
            st_next.lamp_pin = lif.mod_bit;
            st_next.lamp_oe = 1'b1;
        end else if (lamp_on) begin
            if (st_reg.lamp[icfg_pkg::LAMP_OD]) begin
                st_next.lamp_pin = 1'b0;
                st_next.lamp_oe = !lamp_val;
            end else begin
                st_next.lamp_pin = lamp_val;
                st_next.lamp_oe = 1'b1;
            end
        end else if (st_reg.lamp[icfg_pkg::LAMP_OD]) begin
            st_next.lamp_pin = 1'b0;
            st_next.lamp_oe = 1'b0;
        end else begin
            st_next.lamp_pin = st_reg.lamp[icfg_pkg::LAMP_INV];
            st_next.lamp_oe = 1'b1;
        end

        // test view only makes sense while quadrature outputs run
        if (st_reg.test[icfg_pkg::TEST_INDEX] && quad_outputs_enabled_i) begin
            st_next.qa = raw_index_i;
            st_next.qb = index_window_i;
            st_next.qz = gated_index_i;
        end else begin
            st_next.qa = quad_a_i;
            st_next.qb = quad_b_i;
            st_next.qz = quad_z_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
            st_reg.cal_sync <= 2'h3;
            st_reg.cal_prev <= 1'b1;
            st_reg.irq_out <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    icfg_lamp_dsm u_dsm (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .lamp(lif.modu)
    );

    icfg_ratio_decode u_dec (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .comm_i(st_reg.comm),
        .elow_i(st_reg.elow),
        .ehigh_i(st_reg.ehigh),
        .pole_cycles_o(pole_cycles_o),
        .interp_code_o(interp_code_o),
        .output_cycles_o(output_cycles_o),
        .interp_reserved_o(interp_reserved_o),
        .post_div_on_o(post_div_on_o),
        .post_div_ratio_o(post_div_ratio_o)
    );

    assign reg_rdata_o = st_reg.rdata;
    assign reg_rvalid_o = st_reg.rvalid;
    assign nvm_write_o = st_reg.nvm_wr;
    assign link_active_o = st_reg.link_active;
    assign interrupt_out_n_o = st_reg.irq_out;
    assign interrupt_out_n_oe_o = st_reg.irq_oe;
    assign lamp_o = st_reg.lamp_pin;
    assign lamp_oe_o = st_reg.lamp_oe;
    assign quad_a_o = st_reg.qa;
    assign quad_b_o = st_reg.qb;
    assign quad_z_o = st_reg.qz;
    assign input_range_o = st_reg.core[icfg_pkg::CORE_RANGE +: 2];
    assign sensor_loss_detect_o = (input_range_o == icfg_pkg::RANGE_LOW_LOSS)
        || (input_range_o == icfg_pkg::RANGE_HIGH_LOSS);
    assign high_range_atten_o = (input_range_o == icfg_pkg::RANGE_HIGH_LOSS);
    assign heavy_filter_o = st_reg.core[icfg_pkg::CORE_FILTER];
    assign line_driver_on_o = st_reg.core[icfg_pkg::CORE_DRIVER];

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    chk_range_attn: assert property (input_range_o == 2'h2
        |-> high_range_atten_o && sensor_loss_detect_o)
        else $error("high range must attenuate and detect loss");
    chk_filter_write: assert property (reg_wr_i && !nvm_load_i
        && reg_addr_i == icfg_pkg::ADDR_CORE
        |=> heavy_filter_o == $past(reg_wdata_i[2]))
        else $error("filter bit did not follow write");
    chk_driver_write: assert property (reg_wr_i && !nvm_load_i
        && reg_addr_i == icfg_pkg::ADDR_CORE
        |=> line_driver_on_o == $past(reg_wdata_i[3]))
        else $error("line driver bit did not follow write");
    chk_irq_opendrain: assert property (interrupt_out_n_oe_o
        && !$past(st_reg.core[icfg_pkg::CORE_IRQ_PP])
        |-> !interrupt_out_n_o)
        else $error("open-drain interrupt drove high");
    chk_link_ignored: assert property (!link_active_o
        && st_reg.core[icfg_pkg::CORE_LINK_OFF] |=> !link_active_o)
        else $error("link activated while disabled");
    chk_lamp_float: assert property (!calibrating && !lamp_on
        && st_reg.lamp[icfg_pkg::LAMP_OD] |=> !lamp_oe_o)
        else $error("disabled open-drain lamp pin driven");
    chk_duty_write: assert property (reg_wr_i && !nvm_load_i
        && !nvm_done_i && reg_addr_i == icfg_pkg::ADDR_DUTY
        |=> st_reg.duty == $past(reg_wdata_i))
        else $error("duty write not taken at once");
    chk_test_clear: assert property (nvm_done_i
        |=> st_reg.test == 8'h00)
        else $error("test register not cleared at startup");
    chk_nvm_locked: assert property (nvm_cmd_write_i
        && !st_reg.test[icfg_pkg::TEST_UNLOCK] && !cal_rise
        |=> !nvm_write_o)
        else $error("memory written while locked");
    chk_cal_duty: assert property (calibrating
        |-> lif.duty == st_reg.start)
        else $error("calibration not on start value");
    chk_auto_step: assert property (auto_on && !calibrating
        && adj_tick && amp_low && st_reg.duty != 8'hFF && !wr_any
        && !nvm_done_i |=> st_reg.duty == $past(st_reg.duty) + 8'h01)
        else $error("auto control did not raise duty");

    cov_cal_write: cover property (cal_rise ##1 nvm_write_o);
    cov_auto_down: cover property (auto_on && adj_tick && amp_high
        && !amp_low);
    cov_link_on: cover property ($rose(link_active_o));
endmodule // icfg_regs

// ---- testbench/tb_interpolator_config_regs.sv ----
// Purpose: self-checking bench for the interpolator register bank
// Assumes: strobes are taken on the edge after they are driven
// Notes: short control-loop period keeps the auto lamp steps quick
`timescale 1ns/10ps
module tb_interpolator_config_regs;
    logic core_clk_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
    logic [15:0] reg_addr_i, nvm_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, nvm_data_i, q, v;
    logic nvm_load_i, nvm_done_i, nvm_cmd_write_i, nvm_write_o;
    logic calibrate_pin_n_i, calib_cmd_active_i, link_activate_i;
    logic link_active_o, irq_request_i, interrupt_out_n_o;
    logic interrupt_out_n_oe_o, lamp_o, lamp_oe_o, quad_outputs_enabled_i;
    logic quad_a_i, quad_b_i, quad_z_i, raw_index_i, index_window_i;
    logic gated_index_i, quad_a_o, quad_b_o, quad_z_o;
    logic [7:0] signal_amplitude_i, amplitude_low_limit_i;
    logic [7:0] amplitude_high_limit_i;
    logic [1:0] input_range_o;
    logic sensor_loss_detect_o, high_range_atten_o, heavy_filter_o;
    logic line_driver_on_o, interp_reserved_o, post_div_on_o;
    logic [5:0] pole_cycles_o;
    logic [9:0] interp_code_o, code;
    logic [8:0] output_cycles_o;
    logic [3:0] post_div_ratio_o;
    logic [6:0] bg;
    logic [31:0] seed = 32'h0000_5a04;
    int mismatches, num_checks, n;
    // 16'h0003 is unmapped: reads zero, writes dropped
    logic [15:0] addrs [9] = '{icfg_pkg::ADDR_CORE, icfg_pkg::ADDR_LAMP,
        icfg_pkg::ADDR_START, icfg_pkg::ADDR_TEST, icfg_pkg::ADDR_DUTY,
        icfg_pkg::ADDR_COMM, icfg_pkg::ADDR_ELOW, icfg_pkg::ADDR_EHIGH,
        16'h0003};
    logic [7:0] masks [9] = '{icfg_pkg::MASK_CORE, 8'hff, 8'hff,
        icfg_pkg::MASK_TEST, 8'hff, icfg_pkg::MASK_COMM, 8'hff,
        icfg_pkg::MASK_EHIGH, 8'h00};
    wire logic [7:0] core_seen = {input_range_o, sensor_loss_detect_o,
        high_range_atten_o, heavy_filter_o, line_driver_on_o,
        interrupt_out_n_o, interrupt_out_n_oe_o};

    icfg_regs #(.ADJ_PERIOD(4)) dut (.*);

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    // index test sources toggle so the output muxes see traffic
    always @(posedge core_clk_i) begin
        bg <= bg + 7'h01;
        {quad_outputs_enabled_i, quad_a_i, quad_b_i, quad_z_i, raw_index_i,
            index_window_i, gated_index_i} <= bg;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic logic [8:0] cycles(input logic [9:0] c);
        if (c == 10'h000) return 9'h100;
        return (c < 10'h008) ? 9'h000 : {1'b0, c[9:2]};
    endfunction

    function automatic logic [7:0] core_exp(input logic [7:0] c,
                                            input logic rq);
        return {c[1:0], c[1:0] != 2'h0, c[1:0] == 2'h2, c[2], c[3],
            ~rq, c[4] | rq};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h, expected %h",
                $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge core_clk_i);
        #1;
    endtask

    task automatic do_reset();
        @(posedge core_clk_i);
        resetn_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        resetn_i <= 1'b1;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        chk(16'(reg_rvalid_o), 16'h0001);
        d = reg_rdata_o;
    endtask

    task automatic nvm(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        nvm_load_i <= 1'b1;
        nvm_addr_i <= a;
        nvm_data_i <= d;
        @(posedge core_clk_i);
        nvm_load_i <= 1'b0;
    endtask

    // lamp high count over 512 cycles stands in for its duty
    task automatic count_high(output int c);
        c = 0;
        repeat (512) begin
            @(posedge core_clk_i);
            c += int'(lamp_o === 1'b1);
        end
    endtask

    initial begin
        {reg_wr_i, reg_rd_i, nvm_load_i, nvm_done_i, nvm_cmd_write_i} = '0;
        {calib_cmd_active_i, link_activate_i, irq_request_i, bg} = '0;
        {reg_addr_i, nvm_addr_i, reg_wdata_i, nvm_data_i} = '0;
        {resetn_i, calibrate_pin_n_i} = 2'h1;
        {signal_amplitude_i, amplitude_low_limit_i} = 16'h8010;
        amplitude_high_limit_i = 8'hf0;
        {quad_outputs_enabled_i, quad_a_i, quad_b_i, quad_z_i} = '0;
        {raw_index_i, index_window_i, gated_index_i} = '0;
        do_reset();
        for (int p = 0; p < 3; p++) begin
            for (int i = 0; i < 9; i++) begin
                v = rnd();
                if (p > 0) wr(addrs[i], v);
                rd(addrs[i], q);
                chk(16'(q), 16'(v & masks[i] & {8{p > 0}}));
            end
        end
        for (int r = 0; r < 3; r++) begin
            v = {2'h0, r != 2, 3'(rnd() >> 2), 2'(r)};
            irq_request_i <= rnd() > 8'h7f;
            wr(addrs[0], v);
            @(posedge core_clk_i);
            link_activate_i <= 1'b1;
            @(posedge core_clk_i);
            link_activate_i <= 1'b0;
            step(1);
            chk(16'(core_seen),
                16'(core_exp(v, irq_request_i)));
            chk(16'(link_active_o), 16'(r == 2));
        end
        for (int i = 0; i < 13; i++) begin
            v = rnd();
            code = (i < 9) ? 10'(i) : (i == 9) ? 10'h3ff : {v[1:0], rnd()};
            wr(addrs[5], {3'h0, v[6:2]});
            wr(addrs[6], code[7:0]);
            wr(addrs[7], {3'h0, v[4:2], code[9:8]});
            step(1);
            chk(16'(pole_cycles_o),
                (v[6:2] == 5'h00) ? 16'h0020 : 16'(v[6:2]));
            chk(16'(interp_code_o), 16'(code));
            chk(16'({interp_reserved_o, output_cycles_o}),
                16'({code != 0 && code < 8, cycles(code)}));
            chk(16'(post_div_on_o), 16'(v[4:2] != 3'h0));
            if (v[4:2] != 3'h0) chk(16'(post_div_ratio_o),
                16'(v[4:2]) + 16'h0001);
        end
        for (int k = 0; k < 4; k++) begin
            wr(addrs[1], {5'h00, k[1], k[0], 1'b0});
            step(2);
            chk(16'({lamp_oe_o, lamp_o | k[1]}),
                16'({~k[1], k[0] | k[1]}));
        end
        do_reset();
        nvm(addrs[1], 8'h01);
        nvm(addrs[2], 8'hc0);
        wr(addrs[3], 8'h05);
        @(posedge core_clk_i);
        nvm_done_i <= 1'b1;
        @(posedge core_clk_i);
        nvm_done_i <= 1'b0;
        rd(addrs[4], q);
        chk(16'(q), 16'h00c0);
        rd(addrs[3], q);
        chk(16'(q), 16'h0000);
        count_high(n);
        chk(16'(n > 307), 16'h0001);
        wr(addrs[4], 8'h40);
        for (int k = 0; k < 2; k++) begin
            wr(addrs[1], {6'h00, k[0], 1'b1});
            count_high(n);
            chk(16'({n > 307, n < 205}), 16'({k[0], ~k[0]}));
        end
        // inverted, enabled settings must not leak into calibration
        for (int j = 0; j < 2; j++) begin
            @(posedge core_clk_i);
            if (j == 0) calib_cmd_active_i <= 1'b1;
            else calibrate_pin_n_i <= 1'b0;
            count_high(n);
            chk(16'({lamp_oe_o, n > 180, n < 332}), 16'h0006);
            @(posedge core_clk_i);
            calib_cmd_active_i <= 1'b0;
            calibrate_pin_n_i <= 1'b1;
        end
        n = 0;
        while (nvm_write_o !== 1'b1) begin
            step(1);
            n++;
            if (n == 8) begin
                mismatches++;
                complete_run();
            end
        end
        chk(16'(nvm_write_o), 16'h0001);
        for (int j = 0; j < 2; j++) begin
            wr(addrs[3], 8'(j));
            @(posedge core_clk_i);
            nvm_cmd_write_i <= 1'b1;
            @(posedge core_clk_i);
            nvm_cmd_write_i <= 1'b0;
            #1;
            chk(16'(nvm_write_o), 16'(j));
        end
        wr(addrs[4], 8'h80);
        for (int k = 0; k < 4; k++) begin
            wr(addrs[3], {5'h00, k[0], 2'h0});
            wr(addrs[1], {2'h0, 2'(k), 4'h1});
            n = 0;
            repeat (128) begin
                @(posedge core_clk_i);
                q = {1'b0, quad_outputs_enabled_i & k[0], quad_a_i, quad_b_i,
                    quad_z_i, raw_index_i, index_window_i, gated_index_i};
                #1;
                n += int'(lamp_o != v[0]);
                v[0] = lamp_o;
                chk(16'({quad_a_o, quad_b_o, quad_z_o}),
                    16'(q[6] ? q[2:0] : q[5:3]));
            end
            chk(16'(n > (8 << k) - 3 && n < (8 << k) + 3),
                16'h0001);
        end
        wr(addrs[1], 8'hc9);
        wr(addrs[4], 8'h40);
        q = 8'h40;
        for (int j = 0; j < 2; j++) begin
            v = q;
            signal_amplitude_i <= j ? 8'hd8 : 8'h28;
            repeat (40) @(posedge core_clk_i);
            rd(addrs[4], q);
            chk(16'(j ? q < v : q > v), 16'h0001);
        end
        complete_run();
    end
endmodule // tb_interpolator_config_regs
